// ==== rtl/ext_bus_pkg.sv ====
`default_nettype none
package ext_bus_pkg;
	// register address on the cpu i/o port space
	localparam logic [15:0] EXT_BUS_SELECT_ADDR = 16'h1C00;
	localparam int PP_FIELD_LSB  = 12;
	localparam int SP1_FIELD_LSB = 10;
	localparam int SP0_FIELD_LSB = 8;
	localparam int ADDR_SEL_LSB  = 0;
	localparam int RSVD_HI_BIT   = 15;
	// writable bits: 14:8 and 5:0; 15, 7, 6 are reserved
	localparam logic [15:0] WRITE_MASK  = 16'h7F3F;
	localparam logic [15:0] RESET_VALUE = 16'h0000;
	localparam logic [15:0] RSVD_VALUE  = 16'h0000;
	localparam int PP_PINS   = 21;
	localparam int SP_PINS   = 6;
	localparam int ADDR_PINS = 6;
	localparam int GPIO_W    = 32;
	typedef enum logic [2:0] {
		PP_MODE0 = 3'h0,
		PP_MODE1 = 3'h1,
		PP_MODE2 = 3'h2,
		PP_MODE3 = 3'h3,
		PP_MODE4 = 3'h4,
		PP_MODE5 = 3'h5,
		PP_MODE6 = 3'h6,
		PP_RSVD  = 3'h7
	} pp_mode_t;
	typedef enum logic [1:0] {
		SP_MODE0 = 2'h0,
		SP_MODE1 = 2'h1,
		SP_MODE2 = 2'h2,
		SP_RSVD  = 2'h3
	} sp_mode_t;
endpackage
`default_nettype wire

// ==== rtl/serial_port_mux.sv ====
`default_nettype none
// one six-pin serial port: code 0 peripheral, 1 audio plus gpio, 2 all gpio
module serial_port_mux
	import ext_bus_pkg::*;
(
	input  wire ext_bus_pkg::sp_mode_t mode,
	input  wire logic [5:0]            mode0Out,
	input  wire logic [5:0]            mode0Oe,
	input  wire logic [3:0]            audioOut,
	input  wire logic [3:0]            audioOe,
	input  wire logic [5:0]            gpioOut,
	input  wire logic [5:0]            gpioOe,
	output logic      [5:0]            pinOut,
	output logic      [5:0]            pinOe
);
	// reserved code leaves pins floating so nothing fights the board
	always_comb begin
		case (mode)
			SP_MODE0: begin
				pinOut = mode0Out;
				pinOe  = mode0Oe;
			end
			SP_MODE1: begin
				pinOut = {gpioOut[5:4], audioOut};
				pinOe  = {gpioOe[5:4], audioOe};
			end
			SP_MODE2: begin
				pinOut = gpioOut;
				pinOe  = gpioOe;
			end
			default: begin
				pinOut = '0;
				pinOe  = '0;
			end
		endcase
	end
endmodule
`default_nettype wire

// ==== rtl/external_bus_pin_mux.sv ====
`default_nettype none
// Notes on behaviour
// - register at port 0x1C00, routing follows next clock
// - each upper address pin individually gpio or address
// - bit 15 reserved, fixed read, writes ignored
// - bits 14:12 parallel port mode, 000 mode 0
// - code 001: spi7, gpio6, uart4, audio2 4
// - code 010: eight gpio
// - code 011: spi4 plus audio3 4
// - code 100: audio2 4 plus uart4
// - code 101: spi4 plus uart4
// - code 110: spi7, audio2, audio3, gpio6
// - serial1 bits 11:10 code 01 audio1 plus gpio
// - serial1 code 10 gpio 11:6; 11 reserved
// - serial0 bits 9:8 code 00 memory card
// - serial0 code 01 audio0 plus gpio 5:4
// - serial0 code 10 gpio 5:0; 11 reserved
// - bits 5:0 give address pins 20:15 to gpio
// - bits 7:6 reserved, fixed read, writes ignored
module external_bus_pin_mux
	import ext_bus_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	input  wire logic [15:0]          ioAddr,
	input  wire logic                 ioWrite,
	input  wire logic                 ioRead,
	input  wire logic [15:0]          ioWdata,
	output logic      [15:0]          ioRdata,
	input  wire logic [6:0]           spiOut,
	input  wire logic [6:0]           spiOe,
	output logic      [6:0]           spiIn,
	input  wire logic [3:0]           uartOut,
	input  wire logic [3:0]           uartOe,
	output logic      [3:0]           uartIn,
	input  wire logic [3:0]           audio2Out,
	input  wire logic [3:0]           audio2Oe,
	output logic      [3:0]           audio2In,
	input  wire logic [3:0]           audio3Out,
	input  wire logic [3:0]           audio3Oe,
	output logic      [3:0]           audio3In,
	input  wire logic [3:0]           audio1Out,
	input  wire logic [3:0]           audio1Oe,
	output logic      [3:0]           audio1In,
	input  wire logic [3:0]           audio0Out,
	input  wire logic [3:0]           audio0Oe,
	output logic      [3:0]           audio0In,
	input  wire logic [5:0]           card0Out,
	input  wire logic [5:0]           card0Oe,
	output logic      [5:0]           card0In,
	input  wire logic [5:0]           card1Out,
	input  wire logic [5:0]           card1Oe,
	output logic      [5:0]           card1In,
	input  wire logic [5:0]           extMemAddr,
	input  wire logic [GPIO_W-1:0]    gpioOut,
	input  wire logic [GPIO_W-1:0]    gpioOe,
	output logic      [GPIO_W-1:0]    gpioIn,
	input  wire logic [PP_PINS-1:0]   ppPinIn,
	output logic      [PP_PINS-1:0]   ppPinOut,
	output logic      [PP_PINS-1:0]   ppPinOe,
	input  wire logic [SP_PINS-1:0]   sp1PinIn,
	output logic      [SP_PINS-1:0]   sp1PinOut,
	output logic      [SP_PINS-1:0]   sp1PinOe,
	input  wire logic [SP_PINS-1:0]   sp0PinIn,
	output logic      [SP_PINS-1:0]   sp0PinOut,
	output logic      [SP_PINS-1:0]   sp0PinOe,
	input  wire logic [ADDR_PINS-1:0] addrPinIn,
	output logic      [ADDR_PINS-1:0] addrPinOut,
	output logic      [ADDR_PINS-1:0] addrPinOe
);
	logic [15:0]           external_bus_select_reg;
	pp_mode_t              parallel_port_route_field;
	sp_mode_t              serial_port1_route_field;
	sp_mode_t              serial_port0_route_field;
	logic [ADDR_PINS-1:0]  addrSel;
	logic                  regHit;
	logic [PP_PINS-1:0]    ppSync1;
	logic [PP_PINS-1:0]    ppIn;
	logic [SP_PINS-1:0]    sp1Sync1;
	logic [SP_PINS-1:0]    sp1In;
	logic [SP_PINS-1:0]    sp0Sync1;
	logic [SP_PINS-1:0]    sp0In;
	logic [ADDR_PINS-1:0]  addrSync1;
	logic [ADDR_PINS-1:0]  addrIn;

	assign regHit = (ioAddr == EXT_BUS_SELECT_ADDR);

	// register write; reserved bits never take data so they stay fixed
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			external_bus_select_reg <= RESET_VALUE;
		end else if (ioWrite && regHit) begin
			external_bus_select_reg <= (ioWdata & WRITE_MASK)
				| (RSVD_VALUE & ~WRITE_MASK);
		end
	end

	// read data registered, as data outputs come from flip-flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ioRdata <= 16'h0000;
		end else if (ioRead && regHit) begin
			ioRdata <= external_bus_select_reg;
		end else begin
			ioRdata <= 16'h0000;
		end
	end

	// field decode; routing follows the register so it acts one clock on
	assign parallel_port_route_field =
		pp_mode_t'(external_bus_select_reg[PP_FIELD_LSB +: 3]);
	assign serial_port1_route_field =
		sp_mode_t'(external_bus_select_reg[SP1_FIELD_LSB +: 2]);
	assign serial_port0_route_field =
		sp_mode_t'(external_bus_select_reg[SP0_FIELD_LSB +: 2]);
	assign addrSel =
		external_bus_select_reg[ADDR_SEL_LSB +: ADDR_PINS];

	// pad inputs come from outside, two flops before any mux reads them
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ppSync1   <= '0;
			ppIn      <= '0;
			sp1Sync1  <= '0;
			sp1In     <= '0;
			sp0Sync1  <= '0;
			sp0In     <= '0;
			addrSync1 <= '0;
			addrIn    <= '0;
		end else begin
			ppSync1   <= ppPinIn;
			ppIn      <= ppSync1;
			sp1Sync1  <= sp1PinIn;
			sp1In     <= sp1Sync1;
			sp0Sync1  <= sp0PinIn;
			sp0In     <= sp0Sync1;
			addrSync1 <= addrPinIn;
			addrIn    <= addrSync1;
		end
	end

	// parallel port output routing; pin slots chosen per mode, low first
	always_comb begin
		ppPinOut = '0;
		ppPinOe  = '0;
		case (parallel_port_route_field)
			PP_MODE1: begin
				ppPinOut = {audio2Out, uartOut, gpioOut[20:18],
					gpioOut[29:27], spiOut};
				ppPinOe  = {audio2Oe, uartOe, gpioOe[20:18],
					gpioOe[29:27], spiOe};
			end
			PP_MODE2: begin
				ppPinOut = {13'h0000, gpioOut[20:18], gpioOut[31:27]};
				ppPinOe  = {13'h0000, gpioOe[20:18], gpioOe[31:27]};
			end
			PP_MODE3: begin
				ppPinOut = {13'h0000, audio3Out, spiOut[3:0]};
				ppPinOe  = {13'h0000, audio3Oe, spiOe[3:0]};
			end
			PP_MODE4: begin
				ppPinOut = {13'h0000, uartOut, audio2Out};
				ppPinOe  = {13'h0000, uartOe, audio2Oe};
			end
			PP_MODE5: begin
				ppPinOut = {13'h0000, uartOut, spiOut[3:0]};
				ppPinOe  = {13'h0000, uartOe, spiOe[3:0]};
			end
			PP_MODE6: begin
				ppPinOut = {audio3Out, audio2Out, gpioOut[20:18],
					gpioOut[29:27], spiOut};
				ppPinOe  = {audio3Oe, audio2Oe, gpioOe[20:18],
					gpioOe[29:27], spiOe};
			end
			default: begin // mode 0 and code 7 leave pins floating
				ppPinOut = '0;
				ppPinOe  = '0;
			end
		endcase
	end

	// serial port muxes share one module for both ports
	serial_port_mux u_sp1 (
		.mode     (serial_port1_route_field),
		.mode0Out (card1Out),
		.mode0Oe  (card1Oe),
		.audioOut (audio1Out),
		.audioOe  (audio1Oe),
		.gpioOut  (gpioOut[11:6]),
		.gpioOe   (gpioOe[11:6]),
		.pinOut   (sp1PinOut),
		.pinOe    (sp1PinOe)
	);

	serial_port_mux u_sp0 (
		.mode     (serial_port0_route_field),
		.mode0Out (card0Out),
		.mode0Oe  (card0Oe),
		.audioOut (audio0Out),
		.audioOe  (audio0Oe),
		.gpioOut  (gpioOut[5:0]),
		.gpioOe   (gpioOe[5:0]),
		.pinOut   (sp0PinOut),
		.pinOe    (sp0PinOe)
	);

	// address pins: per bit choose gpio 21+i or memory address 15+i
	genvar gi;
	generate
		for (gi = 0; gi < ADDR_PINS; gi++) begin : g_addr
			assign addrPinOut[gi] = addrSel[gi] ? gpioOut[21+gi]
				: extMemAddr[gi];
			assign addrPinOe[gi]  = addrSel[gi] ? gpioOe[21+gi]
				: 1'b1;
		end
	endgenerate

	// input return paths; unselected peripherals see zero
	always_comb begin
		spiIn    = '0;
		uartIn   = '0;
		audio2In = '0;
		audio3In = '0;
		gpioIn[20:0]  = '0;
		gpioIn[31:27] = '0;
		gpioIn[26:21] = addrSel & addrIn;
		case (parallel_port_route_field)
			PP_MODE1: begin
				spiIn = ppIn[6:0];
				gpioIn[29:27] = ppIn[9:7];
				gpioIn[20:18] = ppIn[12:10];
				uartIn   = ppIn[16:13];
				audio2In = ppIn[20:17];
			end
			PP_MODE2: begin
				gpioIn[31:27] = ppIn[4:0];
				gpioIn[20:18] = ppIn[7:5];
			end
			PP_MODE3: begin
				spiIn[3:0] = ppIn[3:0];
				audio3In   = ppIn[7:4];
			end
			PP_MODE4: begin
				audio2In = ppIn[3:0];
				uartIn   = ppIn[7:4];
			end
			PP_MODE5: begin
				spiIn[3:0] = ppIn[3:0];
				uartIn     = ppIn[7:4];
			end
			PP_MODE6: begin
				spiIn = ppIn[6:0];
				gpioIn[29:27] = ppIn[9:7];
				gpioIn[20:18] = ppIn[12:10];
				audio2In = ppIn[16:13];
				audio3In = ppIn[20:17];
			end
			default: begin
				spiIn = '0;
			end
		endcase
		if (serial_port1_route_field == SP_MODE2)
			gpioIn[11:6] = sp1In;
		else if (serial_port1_route_field == SP_MODE1)
			gpioIn[11:10] = sp1In[5:4];
		if (serial_port0_route_field == SP_MODE2)
			gpioIn[5:0] = sp0In;
		else if (serial_port0_route_field == SP_MODE1)
			gpioIn[5:4] = sp0In[5:4];
	end

	assign card1In  = (serial_port1_route_field == SP_MODE0) ? sp1In : '0;
	assign audio1In = (serial_port1_route_field == SP_MODE1)
		? sp1In[3:0] : '0;
	assign card0In  = (serial_port0_route_field == SP_MODE0) ? sp0In : '0;
	assign audio0In = (serial_port0_route_field == SP_MODE1)
		? sp0In[3:0] : '0;

	// checks
	a_write_takes: assert property (@(posedge clk) disable iff (!arst_n)
		ioWrite && regHit |=> external_bus_select_reg
			== ($past(ioWdata) & WRITE_MASK))
		else $error("select register did not take write");
	a_rsvd_fixed: assert property (@(posedge clk) disable iff (!arst_n)
		external_bus_select_reg[RSVD_HI_BIT] == 1'b0
			&& external_bus_select_reg[7:6] == 2'b00)
		else $error("reserved bits changed");
	a_addr_gpio: assert property (@(posedge clk) disable iff (!arst_n)
		addrSel[0] |-> addrPinOut[0] == gpioOut[21])
		else $error("address pin 15 not gpio 21");
	a_addr_mem: assert property (@(posedge clk) disable iff (!arst_n)
		!addrSel[5] |-> addrPinOut[5] == extMemAddr[5] && addrPinOe[5])
		else $error("address pin 20 lost memory function");
	a_pp_rsvd_float: assert property (@(posedge clk) disable iff (!arst_n)
		parallel_port_route_field == PP_RSVD |-> ppPinOe == '0)
		else $error("parallel pins driven on reserved code");
	a_pp_mode2_gpio: assert property (@(posedge clk) disable iff (!arst_n)
		parallel_port_route_field == PP_MODE2 |->
			ppPinOut[4:0] == gpioOut[31:27] && ppPinOe[20:8] == '0)
		else $error("mode 2 gpio routing wrong");
	a_pp_mode5_route: assert property (@(posedge clk) disable iff (!arst_n)
		parallel_port_route_field == PP_MODE5 |->
			ppPinOut[7:4] == uartOut && ppPinOut[3:0] == spiOut[3:0])
		else $error("mode 5 routing wrong");
	a_sp0_card: assert property (@(posedge clk) disable iff (!arst_n)
		serial_port0_route_field == SP_MODE0 |-> sp0PinOut == card0Out)
		else $error("serial port 0 card routing wrong");
	a_sp1_rsvd: assert property (@(posedge clk) disable iff (!arst_n)
		serial_port1_route_field == SP_RSVD |-> sp1PinOe == '0)
		else $error("serial port 1 driven on reserved code");
	c_write: cover property (@(posedge clk) disable iff (!arst_n)
		ioWrite && regHit);
	c_pp_mode6: cover property (@(posedge clk) disable iff (!arst_n)
		parallel_port_route_field == PP_MODE6);
	c_sp1_gpio: cover property (@(posedge clk) disable iff (!arst_n)
		serial_port1_route_field == SP_MODE2);
	c_addr_all: cover property (@(posedge clk) disable iff (!arst_n)
		addrSel == 6'h3F);
endmodule
`default_nettype wire

// ==== verif/pad_model.sv ====
`default_nettype none
// board side of a pad group: a driven pad reads back its own level, a
// released pad floats, shown as a level that flips every cycle so a stale
// value never passes for a real one
module pad_model #(
	parameter int W = 6
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] pinOut,
	input  wire logic [W-1:0] pinOe,
	output logic      [W-1:0] pinIn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [W-1:0] floatLvl;
	// floating level, toggled each cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			floatLvl <= '0;
		end else begin
			floatLvl <= ~floatLvl;
		end
	end
	// wire level worked out from the single driver's enable
	assign pinIn = (pinOe & pinOut) | (~pinOe & floatLvl);
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
`default_nettype none
module tb_top
	import ext_bus_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, arst_n, ioWrite, ioRead;
	logic [15:0] ioAddr, ioWdata, ioRdata;
	logic [6:0] spiOut, spiOe, spiIn;
	logic [3:0] uartOut, uartOe, uartIn, audio2Out, audio2Oe, audio2In;
	logic [3:0] audio3Out, audio3Oe, audio3In, audio1Out, audio1Oe, audio1In;
	logic [3:0] audio0Out, audio0Oe, audio0In;
	logic [5:0] card0Out, card0Oe, card0In, card1Out, card1Oe, card1In;
	logic [5:0] extMemAddr, addrPinIn, addrPinOut, addrPinOe;
	logic [5:0] sp1PinIn, sp1PinOut, sp1PinOe, sp0PinIn, sp0PinOut, sp0PinOe;
	logic [31:0] gpioOut, gpioOe, gpioIn;
	logic [20:0] ppPinIn, ppPinOut, ppPinOe;
	int num_errors = 0;
	int n_checks = 0;
	external_bus_pin_mux uut (
		.clk, .arst_n, .ioAddr, .ioWrite, .ioRead, .ioWdata, .ioRdata,
		.spiOut, .spiOe, .spiIn, .uartOut, .uartOe, .uartIn,
		.audio2Out, .audio2Oe, .audio2In, .audio3Out, .audio3Oe, .audio3In,
		.audio1Out, .audio1Oe, .audio1In, .audio0Out, .audio0Oe, .audio0In,
		.card0Out, .card0Oe, .card0In, .card1Out, .card1Oe, .card1In,
		.extMemAddr, .gpioOut, .gpioOe, .gpioIn, .ppPinIn, .ppPinOut,
		.ppPinOe, .sp1PinIn, .sp1PinOut, .sp1PinOe, .sp0PinIn, .sp0PinOut,
		.sp0PinOe, .addrPinIn, .addrPinOut, .addrPinOe);
	pad_model #(.W(PP_PINS)) padPp (.clk, .arst_n, .pinOut(ppPinOut),
		.pinOe(ppPinOe), .pinIn(ppPinIn));
	pad_model #(.W(SP_PINS)) padSp1 (.clk, .arst_n, .pinOut(sp1PinOut),
		.pinOe(sp1PinOe), .pinIn(sp1PinIn));
	pad_model #(.W(SP_PINS)) padSp0 (.clk, .arst_n, .pinOut(sp0PinOut),
		.pinOe(sp0PinOe), .pinIn(sp0PinIn));
	pad_model #(.W(ADDR_PINS)) padAddr (.clk, .arst_n, .pinOut(addrPinOut),
		.pinOe(addrPinOe), .pinIn(addrPinIn));
	// free-running clock, 50 ns period
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// one-cycle strobes, launched just after an edge, taken at the next;
	// peripheral drive sits still across every write, as if clock gated
	task automatic wr(input logic [15:0] a, d);
		@(posedge clk);
		#1 ioAddr = a;
		ioWdata = d;
		ioWrite = 1'b1;
		@(posedge clk);
		#1 ioWrite = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk);
		#1 ioAddr = a;
		ioRead = 1'b1;
		@(posedge clk);
		#1 ioRead = 1'b0;
		d = ioRdata;
	endtask
	function automatic logic [20:0] ppExp(input logic [2:0] m,
		input logic [6:0] s, input logic [3:0] u, a2, a3,
		input logic [31:0] g);
		case (m)
			3'h1: return {a2, u, g[20:18], g[29:27], s};
			3'h2: return {13'h0, g[20:18], g[31:27]};
			3'h3: return {13'h0, a3, s[3:0]};
			3'h4: return {13'h0, u, a2};
			3'h5: return {13'h0, u, s[3:0]};
			3'h6: return {a3, a2, g[20:18], g[29:27], s};
			default: return 21'h0;
		endcase
	endfunction
	function automatic logic [5:0] spExp(input logic [1:0] m,
		input logic [5:0] c, input logic [3:0] a, input logic [5:0] g);
		case (m)
			2'h0: return c;
			2'h1: return {g[5:4], a};
			2'h2: return g;
			default: return 6'h0;
		endcase
	endfunction
	// reset state, reserved bits, unmapped address
	task automatic regScen();
		logic [15:0] d;
		rd(EXT_BUS_SELECT_ADDR, d);
		chk("reset value", d, 16'h0000);
		chk("addr oe", addrPinOe, 6'h3F);
		chk("addr out", addrPinOut, extMemAddr);
		wr(EXT_BUS_SELECT_ADDR, 16'hFFFF);
		rd(EXT_BUS_SELECT_ADDR, d);
		chk("reserved bits", d, 16'h7F3F);
		wr(16'h1C01, 16'h0000);
		rd(16'h1C01, d);
		chk("unmapped read", d, 16'h0000);
		rd(EXT_BUS_SELECT_ADDR, d);
		chk("unmapped write", d, 16'h7F3F);
	endtask
	// each address pin picked on its own, effective one cycle on
	task automatic addrScen();
		logic [5:0] s;
		for (int i = 0; i < 2; i++) begin
			s = i ? 6'h2A : 6'h15;
			wr(EXT_BUS_SELECT_ADDR, {10'h0, s});
			chk("addr out", addrPinOut,
				(s & gpioOut[26:21]) | (~s & extMemAddr));
			chk("addr oe", addrPinOe,
				6'((s & gpioOe[26:21]) | ~s));
			repeat (2) @(posedge clk);
			#1 chk("addr gpio in", gpioIn[26:21] & gpioOe[26:21],
				s & gpioOut[26:21] & gpioOe[26:21]);
		end
	endtask
	task automatic ppScen();
		logic [20:0] om, em;
		// one bit per mode code: which modes route each return path
		logic [7:0] uartM = 8'h32, a2M = 8'h52, a3M = 8'h48;
		logic [7:0] spiM = 8'h42, spiLoM = 8'h28, gM = 8'h46, g2M = 8'h04;
		// each pass is a fresh setup, not live switching of a busy port
		for (int m = 0; m < 8; m++) begin
			wr(EXT_BUS_SELECT_ADDR, 16'(m) << PP_FIELD_LSB);
			om = (m == 1 || m == 6) ? 21'h1F_FFFF :
				(m == 0 || m == 7) ? 21'h0 : 21'hFF;
			em = (m == 0 || m == 7) ? 21'h1F_FFFF : om;
			chk("pp out", ppPinOut & om, ppExp(3'(m), spiOut, uartOut,
				audio2Out, audio3Out, gpioOut) & om);
			chk("pp oe", ppPinOe & em, ppExp(3'(m), spiOe, uartOe,
				audio2Oe, audio3Oe, gpioOe) & em);
			// return paths read once both sync flops hold the new route
			repeat (2) @(posedge clk);
			#1 chk("uart in", uartIn & uartOe,
				{4{uartM[m]}} & uartOut & uartOe);
			chk("spi in", spiIn & spiOe, {{3{spiM[m]}},
				{4{spiM[m] | spiLoM[m]}}} & spiOut & spiOe);
			chk("audio2 in", audio2In & audio2Oe,
				{4{a2M[m]}} & audio2Out & audio2Oe);
			chk("audio3 in", audio3In & audio3Oe,
				{4{a3M[m]}} & audio3Out & audio3Oe);
			chk("pp gpio in", gpioIn[31:18] & gpioOe[31:18],
				{{2{g2M[m]}}, {3{gM[m]}}, 6'h00, {3{gM[m]}}}
				& gpioOut[31:18] & gpioOe[31:18]);
		end
	endtask
	task automatic spScen();
		for (int m = 0; m < 4; m++) begin
			wr(EXT_BUS_SELECT_ADDR, (16'(m) << SP1_FIELD_LSB) |
				(16'(m) << SP0_FIELD_LSB));
			if (m < 3) begin
				chk("sp0 out", sp0PinOut,
					spExp(2'(m), card0Out, audio0Out, gpioOut[5:0]));
				chk("sp1 out", sp1PinOut,
					spExp(2'(m), card1Out, audio1Out, gpioOut[11:6]));
			end
			chk("sp0 oe", sp0PinOe,
				spExp(2'(m), card0Oe, audio0Oe, gpioOe[5:0]));
			chk("sp1 oe", sp1PinOe,
				spExp(2'(m), card1Oe, audio1Oe, gpioOe[11:6]));
			// peripherals used only after the sync flops refill
			repeat (2) @(posedge clk);
			#1 chk("card0 in", card0In & card0Oe,
				{6{m == 0}} & card0Out & card0Oe);
			if (m == 0)
				chk("audio0 in", audio0In, 4'h0);
			chk("audio0 act", audio0In & audio0Oe,
				{4{m == 1}} & audio0Out & audio0Oe);
			chk("audio1 in", audio1In & audio1Oe,
				{4{m == 1}} & audio1Out & audio1Oe);
			chk("card1 in", card1In & card1Oe,
				{6{m == 0}} & card1Out & card1Oe);
			chk("sp gpio in", gpioIn[11:0] & gpioOe[11:0],
				{{2{m == 1 || m == 2}}, {4{m == 2}},
				{2{m == 1 || m == 2}}, {4{m == 2}}}
				& gpioOut[11:0] & gpioOe[11:0]);
		end
	endtask
	// watchdog: a hang counts as a mismatch
	initial begin
		#1_000_000;
		num_errors++;
		test_done();
	end
	initial begin
		logic [15:0] d;
		{ioWrite, ioRead, ioAddr, ioWdata} = '0;
		{spiOut, spiOe} = {7'h2D, 7'h5A};
		{uartOut, uartOe, audio2Out, audio2Oe} = 16'h96C3;
		{audio3Out, audio3Oe, audio1Out, audio1Oe} = 16'h5AE1;
		{audio0Out, audio0Oe} = 8'h78;
		{card0Out, card0Oe, card1Out, card1Oe} = 24'hAD_0CCC;
		extMemAddr = 6'h2A;
		gpioOut = 32'hA5C3_5A3C;
		gpioOe = 32'h3C5A_C3A5;
		arst_n = 1'b0;
		repeat (3) @(posedge clk);
		#1 arst_n = 1'b1;
		regScen();
		addrScen();
		ppScen();
		spScen();
		// second reset in mid-run, held across two edges, clears routing
		@(posedge clk);
		#1 arst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 arst_n = 1'b1;
		chk("reset pp oe", ppPinOe, 21'h0);
		chk("reset addr oe", addrPinOe, 6'h3F);
		chk("reset sp1 out", sp1PinOut, card1Out);
		rd(EXT_BUS_SELECT_ADDR, d);
		chk("reset again", d, 16'h0000);
		test_done();
	end
endmodule
`default_nettype wire
